// [dv/mb_function_handler_properties.sv]
// Port-level assertions for the slave message handler.
// Assumes it is bound to every handler instance, one clock, async reset.
`timescale 1ns/1ps
module mb_function_handler_properties
    import mb_handler_pkg::*;
#(
    parameter int MAX_REG_COUNT = MAX_REGS
)
(
    // Clock, reset, station
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] own_addr,
    // Receive side
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_parity_err,
    input wire logic rx_framing_err,
    input wire logic rx_overrun_err,
    input wire logic rx_end,
    // Store side
    input wire logic reg_req,
    input wire logic reg_write,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_ack,
    input wire logic [1:0] reg_status,
    input wire logic [15:0] reg_rdata,
    // Transmit side
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tx_last,
    input wire logic tx_ready,
    input wire logic busy
);
    logic [8:0] cnt;
    wire logic acc = tx_valid && tx_ready;
    // Bytes already accepted in the reply under way
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 9'h000;
        end else if (acc) begin
            cnt <= tx_last ? 9'h000 : cnt + 9'h001;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    idle_quiet_a: assert property (!busy |-> !tx_valid && !reg_req)
        else $error("output active while idle");
    start_cause_a: assert property ($rose(busy) |-> $past(rx_end))
        else $error("busy rose without a frame end");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
        else $error("reply byte changed before acceptance");
    last_valid_a: assert property (tx_last |-> tx_valid)
        else $error("last flag without valid byte");
    req_hold_a: assert property (reg_req && !reg_ack |=> reg_req && $stable(reg_addr))
        else $error("store request dropped or moved before ack");
    addr_step_a: assert property (reg_req && reg_ack ##1 reg_req |->
        reg_addr == $past(reg_addr) + 16'h0001)
        else $error("store address did not step by one");
    reply_addr_a: assert property ($rose(tx_valid) |-> tx_byte == own_addr)
        else $error("reply does not start with station address");
    access_first_a: assert property (reg_req |-> !tx_valid)
        else $error("reply overlaps store access");
    end_idle_a: assert property (acc && tx_last |=> ##[0:1] !busy)
        else $error("busy held after last byte");
    reply_len_a: assert property (acc && tx_last |->
        cnt == 9'h007 || (!cnt[0] && cnt >= 9'h004))
        else $error("reply length not a legal frame size");
    cover property (acc && tx_last);
    cover property (reg_ack && reg_write && reg_status == ST_OK);
    cover property (reg_ack && reg_status == ST_BAD_DATA);
endmodule

bind mb_function_handler mb_function_handler_properties #(.MAX_REG_COUNT(MAX_REG_COUNT)) i_props (
    .clk(clk), .resetn(resetn), .own_addr(own_addr), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_parity_err(rx_parity_err), .rx_framing_err(rx_framing_err),
    .rx_overrun_err(rx_overrun_err), .rx_end(rx_end), .reg_req(reg_req),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack),
    .reg_status(reg_status), .reg_rdata(reg_rdata), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_last(tx_last), .tx_ready(tx_ready), .busy(busy));

// [dv/mb_master_model.sv]
// Serial master model: sends framed queries, collects reply bytes.
// Assumes the handler's clock; drives its lines at the falling edge.
`timescale 1ns/1ps
module mb_master_model (
    // Clock
    input wire logic clk,
    // Query bytes
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic rx_parity_err,
    output logic rx_framing_err,
    output logic rx_overrun_err,
    output logic rx_end,
    // Reply bytes
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tx_last,
    output logic tx_ready
);
    logic [7:0] resp[$];
    logic stall = 1'b0;
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        rx_parity_err = 1'b0;
        rx_framing_err = 1'b0;
        rx_overrun_err = 1'b0;
        rx_end = 1'b0;
        tx_ready = 1'b1;
    end
    // Stalling sink drops tx_ready every other cycle to stretch the reply
    always @(negedge clk) tx_ready <= stall ? ~tx_ready : 1'b1;
    always @(posedge clk) if (tx_valid && tx_ready) resp.push_back(tx_byte);
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    // Fault 1..3 flags the last byte, 4 spoils the CRC
    task automatic send(input logic [7:0] q[$], input int fault);
        logic [15:0] c;
        logic last;
        c = crc16(q);
        if (fault == 4) c = ~c;
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        foreach (q[i]) begin
            last = (i == q.size() - 1);
            @(negedge clk);
            rx_valid = 1'b1;
            rx_byte = q[i];
            rx_parity_err = (fault == 1) && last;
            rx_framing_err = (fault == 2) && last;
            rx_overrun_err = (fault == 3) && last;
            @(negedge clk);
            rx_valid = 1'b0;
            rx_byte = ~q[i];
            rx_parity_err = 1'b0;
            rx_framing_err = 1'b0;
            rx_overrun_err = 1'b0;
        end
        @(negedge clk);
        rx_end = 1'b1;
        @(negedge clk);
        rx_end = 1'b0;
    endtask
endmodule

// [dv/test_mb_function_handler.sv]
// Self-checking bench for the slave message handler.
// Assumes a store with 16 words; registers 0x.F. are missing, 0xdead is refused.
`timescale 1ns/1ps
module test_mb_function_handler;
    import mb_handler_pkg::*;
    logic clk, resetn, rx_valid, rx_parity_err, rx_framing_err, rx_overrun_err, rx_end;
    logic reg_req, reg_write, reg_ack, tx_valid, tx_last, tx_ready, busy;
    logic [7:0] own_addr, rx_byte, tx_byte;
    logic [15:0] reg_addr, reg_wdata, reg_rdata;
    logic [1:0] reg_status, st;
    logic [15:0] mem[16];
    logic [7:0] none[$];
    int n_mismatch = 0;
    int num_checks = 0;
    mb_function_handler i_mb_function_handler (.clk(clk), .resetn(resetn), .own_addr(own_addr),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_parity_err(rx_parity_err),
        .rx_framing_err(rx_framing_err), .rx_overrun_err(rx_overrun_err), .rx_end(rx_end),
        .reg_req(reg_req), .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_ack(reg_ack), .reg_status(reg_status), .reg_rdata(reg_rdata),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last), .tx_ready(tx_ready),
        .busy(busy));
    mb_master_model i_mb_master_model (.clk(clk), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .rx_parity_err(rx_parity_err), .rx_framing_err(rx_framing_err),
        .rx_overrun_err(rx_overrun_err), .rx_end(rx_end), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .tx_last(tx_last), .tx_ready(tx_ready));
    assign st = (reg_addr[7:4] == 4'hf) ? ST_NO_REG :
        (reg_write && reg_wdata == 16'hdead) ? ST_BAD_DATA : ST_OK;
    // Store acks every other cycle; read data is junk except for existing words
    always @(negedge clk) begin
        reg_ack <= reg_req && !reg_ack;
        reg_status <= ST_BAD_DATA;
        reg_rdata <= ~reg_rdata;
        if (reg_req && !reg_ack) begin
            reg_status <= st;
            reg_rdata <= (st == ST_NO_REG) ? 16'hbeef : mem[reg_addr[3:0]];
            if (reg_write && st == ST_OK) mem[reg_addr[3:0]] <= reg_wdata;
        end
    end
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One query, then the whole reply with its CRC; empty means silence
    task automatic run(input logic [7:0] q[$], input int fault, input logic [7:0] exp[$]);
        logic [15:0] c;
        i_mb_master_model.resp.delete();
        i_mb_master_model.send(q, fault);
        repeat (3) @(negedge clk);
        for (int n = 0; n < 400 && busy !== 1'b0; n++) @(negedge clk);
        check_byte({7'h00, busy}, 8'h00);
        if (exp.size() > 0) begin
            c = i_mb_master_model.crc16(exp);
            exp.push_back(c[7:0]);
            exp.push_back(c[15:8]);
        end
        check_byte(8'(i_mb_master_model.resp.size()), 8'(exp.size()));
        foreach (exp[i]) check_byte(i_mb_master_model.resp[i], exp[i]);
    endtask
    task automatic t_write_echo();
        run('{8'h19, 8'h10, 8'h03, 8'hee, 8'h00, 8'h02, 8'h04, 8'h00, 8'h05, 8'h00, 8'h0a}, 0,
            '{8'h19, 8'h10, 8'h03, 8'hee, 8'h00, 8'h02});
        check_byte(i_mb_master_model.resp[6], 8'h22);
        check_byte(i_mb_master_model.resp[7], 8'h61);
        check_word(mem[4'he], 16'h0005);
        check_word(mem[4'hf], 16'h000a);
        run('{8'h19, 8'h46}, 0, '{8'h19, 8'h46, 8'h03, 8'hee, 8'h00, 8'h02});
    endtask
    task automatic t_partial();
        run('{8'h19, 8'h10, 8'h00, 8'hef, 8'h00, 8'h02, 8'h04, 8'h11, 8'h11, 8'h22, 8'h22}, 0,
            '{8'h19, 8'h10, 8'h00, 8'hef, 8'h00, 8'h02});
        check_word(mem[4'hf], 16'h1111);
        check_word(mem[4'h0], 16'h0000);
        run('{8'h19, 8'h03, 8'h00, 8'hef, 8'h00, 8'h02}, 0,
            '{8'h19, 8'h03, 8'h04, 8'h11, 8'h11, 8'h00, 8'h00});
        run('{8'h19, 8'h46}, 0, '{8'h19, 8'h46, 8'h00, 8'hef, 8'h00, 8'h01});
    endtask
    task automatic t_exceptions();
        i_mb_master_model.stall = 1'b1;
        run('{8'h19, 8'h10, 8'h00, 8'hf0, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34}, 0,
            '{8'h19, 8'h90, 8'h02});
        run('{8'h19, 8'h46}, 0, '{8'h19, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00});
        run('{8'h19, 8'h10, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02, 8'hde, 8'had}, 0,
            '{8'h19, 8'h90, 8'h03});
        run('{8'h19, 8'h10, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00}, 0,
            '{8'h19, 8'h90, 8'h03});
        fork
            run('{8'h19, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01}, 0,
                '{8'h19, 8'h03, 8'h02, 8'h00, 8'h00});
            begin
                // Second query lands while busy and must draw no answer
                wait (busy === 1'b1);
                i_mb_master_model.send('{8'h19, 8'h46}, 0);
            end
        join
        run('{8'h19, 8'h46, 8'h00}, 0, '{8'h19, 8'hc6, 8'h03});
        run('{8'h19, 8'h07}, 0, '{8'h19, 8'h87, 8'h01});
        run('{8'h19, 8'h46}, 0, '{8'h19, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00});
        i_mb_master_model.stall = 1'b0;
    endtask
    task automatic t_silent();
        for (int f = 1; f <= 4; f++) run('{8'h19, 8'h46}, f, none);
        run('{8'h19}, 0, none);
        run('{8'h2a, 8'h46}, 0, none);
        run('{8'h00, 8'h07}, 0, none);
        run('{8'h00, 8'h10, 8'h00, 8'h02, 8'h00, 8'h01, 8'h02, 8'hab, 8'hcd}, 0, none);
        check_word(mem[4'h2], 16'habcd);
    endtask
    task automatic conclude();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        resetn = 1'b0;
        own_addr = 8'h19;
        reg_ack = 1'b0;
        reg_status = ST_OK;
        reg_rdata = 16'h0000;
        foreach (mem[i]) mem[i] = 16'h0000;
        repeat (8) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        t_write_echo();
        t_partial();
        t_exceptions();
        t_silent();
        conclude();
    end
    // Under 1,000 cycles expected; 50,000 leaves ample margin for stalls
    initial begin
        #200000;
        n_mismatch++;
        conclude();
    end
endmodule

// [rtl/crc16_rtu.sv]
// Reflected CRC-16 accumulator, one byte per enable.
// Assumes data is held stable in the enable cycle.
`timescale 1ns/1ps
module crc16_rtu
    import mb_handler_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Byte feed
    input wire logic clear,
    input wire logic en,
    input wire logic [7:0] data,
    // Remainder
    output logic [15:0] crc,
    output logic [15:0] crc_next
);
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int b = 0; b < 8; b++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    always_comb begin
        crc_next = crc_byte(crc, data);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            crc <= CRC_INIT;
        end else if (clear) begin
            crc <= CRC_INIT;
        end else if (en) begin
            crc <= crc_next;
        end
    end
endmodule

// [rtl/mb_function_handler.sv]
// Slave message handler: multi-write, holding read, access log, exceptions.
// Assumes same-clock framing layer upstream and a handshaked parameter store.
`timescale 1ns/1ps
module mb_function_handler
    import mb_handler_pkg::*;
#(
    parameter int MAX_REG_COUNT = MAX_REGS
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Own station address
    input wire logic [7:0] own_addr,
    // Received bytes from framing layer
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_parity_err,
    input wire logic rx_framing_err,
    input wire logic rx_overrun_err,
    input wire logic rx_end,
    // Parameter store access
    output logic reg_req,
    output logic reg_write,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire logic reg_ack,
    input wire logic [1:0] reg_status,
    input wire logic [15:0] reg_rdata,
    // Response bytes
    output logic tx_valid,
    output logic [7:0] tx_byte,
    output logic tx_last,
    input wire logic tx_ready,
    // Status
    output logic busy
);
    state_t state;
    resp_t resp_kind;
    logic [7:0] frame [FRAME_BYTES];
    logic [15:0] rd_data [MAX_REG_COUNT];
    logic [8:0] rx_len;
    logic rx_bad;
    logic [15:0] rx_crc;
    logic [8:0] frame_len;
    logic [15:0] start_addr;
    logic [15:0] reg_count;
    logic [7:0] exc_code;
    logic [6:0] acc_idx;
    logic [7:0] ok_count;
    logic data_bad;
    logic [15:0] log_start;
    logic [15:0] log_count;
    logic [8:0] tx_idx;
    logic [8:0] body_len;
    logic [8:0] sel_idx;
    logic [7:0] body_byte;
    logic [15:0] tx_crc;
    logic [15:0] tx_crc_next;
    logic tx_fire;
    logic bcast;
    logic [7:0] func;
    logic [7:0] byte_cnt;
    logic [6:0] last_idx;

    assign busy = (state != S_IDLE);
    assign bcast = (frame[0] == BCAST_ADDR);
    assign func = frame[1];
    assign byte_cnt = frame[6];
    assign tx_valid = (state == S_SEND);
    assign tx_fire = tx_valid && tx_ready;
    assign tx_last = tx_valid && (tx_idx == body_len + 9'd1);
    assign reg_req = (state == S_ACCESS);
    assign last_idx = reg_count[6:0] - 7'd1;

    // Receive side; the whole frame is checked at its end
    crc16_rtu u_rx_crc (
        .clk(clk),
        .resetn(resetn),
        .clear(rx_end),
        .en(rx_valid && state == S_IDLE),
        .data(rx_byte),
        .crc(rx_crc),
        .crc_next()
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_len <= 9'h000;
            frame_len <= 9'h000;
            rx_bad <= 1'b0;
        end else if (rx_end) begin
            // Length kept for decode while rx_len restarts for the next frame
            frame_len <= rx_len;
            rx_len <= 9'h000;
            rx_bad <= 1'b0;
        end else if (rx_valid) begin
            if (state != S_IDLE || rx_len == 9'(FRAME_BYTES)) begin
                rx_bad <= 1'b1;
            end else begin
                rx_len <= rx_len + 9'd1;
            end
            if (rx_parity_err || rx_framing_err || rx_overrun_err) begin
                rx_bad <= 1'b1;
            end
        end
    end

    // Frame store holds the query until the answer is sent
    always_ff @(posedge clk) begin
        if (rx_valid && state == S_IDLE && rx_len < 9'(FRAME_BYTES)) begin
            frame[rx_len[7:0]] <= rx_byte;
        end
    end

    // Read data gathered during the access loop
    always_ff @(posedge clk) begin
        if (state == S_ACCESS && reg_ack && !reg_write) begin
            rd_data[acc_idx] <= (reg_status == ST_NO_REG) ? 16'h0000 : reg_rdata;
        end
    end

    // Main sequence
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= S_IDLE;
            resp_kind <= R_EXC;
            exc_code <= 8'h00;
            start_addr <= 16'h0000;
            reg_count <= 16'h0000;
        end else begin
            case (state)
                S_IDLE: begin
                    // Short, corrupt or busy-overlapped frames end silently
                    if (rx_end && !rx_bad && rx_len >= 9'(MIN_FRAME) && rx_crc == 16'h0000
                        && (frame[0] == own_addr || frame[0] == BCAST_ADDR)) begin
                        state <= S_DECODE;
                    end
                end
                S_DECODE: begin
                    start_addr <= {frame[2], frame[3]};
                    reg_count <= {frame[4], frame[5]};
                    state <= bcast ? S_IDLE : S_LOAD;
                    case (func)
                        FC_READ_HOLD: begin
                            if (frame_len != READ_QUERY_LEN || {frame[4], frame[5]} == 16'h0000
                                || {frame[4], frame[5]} > 16'(MAX_REG_COUNT)) begin
                                resp_kind <= R_EXC;
                                exc_code <= EXC_DATA;
                            end else begin
                                state <= S_ACCESS;
                            end
                        end
                        FC_WRITE_MULTI: begin
                            // Count bound keeps the count within the 7-bit access index
                            if (frame_len != WRITE_HDR_LEN + {1'b0, byte_cnt}
                                || {frame[4], frame[5]} == 16'h0000
                                || {frame[4], frame[5]} > 16'(MAX_REG_COUNT)
                                || {1'b0, byte_cnt} != {frame[5], 1'b0}) begin
                                resp_kind <= R_EXC;
                                exc_code <= EXC_DATA;
                            end else begin
                                state <= S_ACCESS;
                            end
                        end
                        FC_ACCESS_LOG: begin
                            // Broadcast log queries are dropped above
                            if (frame_len != LOG_QUERY_LEN) begin
                                resp_kind <= R_EXC;
                                exc_code <= EXC_DATA;
                            end else begin
                                resp_kind <= R_LOG;
                            end
                        end
                        default: begin
                            resp_kind <= R_EXC;
                            exc_code <= EXC_FUNCTION;
                        end
                    endcase
                end
                S_ACCESS: begin
                    if (reg_ack && acc_idx == last_idx) begin
                        state <= S_FINISH;
                    end
                end
                S_FINISH: begin
                    state <= bcast ? S_IDLE : S_LOAD;
                    if (data_bad) begin
                        resp_kind <= R_EXC;
                        exc_code <= EXC_DATA;
                    end else if (ok_count == 8'h00) begin
                        resp_kind <= R_EXC;
                        exc_code <= EXC_ADDRESS;
                    end else begin
                        // Partial success is still a normal answer
                        resp_kind <= (func == FC_READ_HOLD) ? R_READ : R_ECHO;
                    end
                    if (bcast && (data_bad || ok_count == 8'h00)) begin
                        state <= S_IDLE;
                    end
                end
                S_LOAD: begin
                    state <= S_SEND;
                end
                S_SEND: begin
                    if (tx_fire && tx_last) begin
                        state <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // Store access loop; one register per acknowledge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc_idx <= 7'h00;
            ok_count <= 8'h00;
            data_bad <= 1'b0;
            reg_write <= 1'b0;
            reg_addr <= 16'h0000;
            reg_wdata <= 16'h0000;
        end else if (state == S_DECODE) begin
            acc_idx <= 7'h00;
            ok_count <= 8'h00;
            data_bad <= 1'b0;
            reg_write <= (func == FC_WRITE_MULTI);
            reg_addr <= {frame[2], frame[3]};
            reg_wdata <= {frame[7], frame[8]};
        end else if (state == S_ACCESS && reg_ack) begin
            acc_idx <= acc_idx + 7'd1;
            reg_addr <= reg_addr + 16'd1;
            reg_wdata <= {frame[8'(9 + 2 * acc_idx)], frame[8'(10 + 2 * acc_idx)]};
            if (reg_status == ST_OK) begin
                ok_count <= ok_count + 8'd1;
            end
            if (reg_status == ST_BAD_DATA) begin
                data_bad <= 1'b1;
            end
        end
    end

    // Access log; a log query leaves it alone
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            log_start <= 16'h0000;
            log_count <= 16'h0000;
        end else if (state == S_DECODE && func != FC_ACCESS_LOG) begin
            // Cleared up front so a query refused at decode logs nothing
            log_start <= 16'h0000;
            log_count <= 16'h0000;
        end else if (state == S_FINISH) begin
            if (data_bad || ok_count == 8'h00) begin
                log_start <= 16'h0000;
                log_count <= 16'h0000;
            end else begin
                log_start <= start_addr;
                log_count <= {8'h00, ok_count};
            end
        end
    end

    // Response body selection
    always_comb begin
        sel_idx = (state == S_LOAD) ? 9'h000 : tx_idx + 9'd1;
        body_byte = frame[0];
        case (resp_kind)
            R_ECHO: begin
                body_len = ECHO_LEN;
                body_byte = frame[sel_idx[7:0]];
            end
            R_READ: begin
                body_len = READ_HDR_LEN + {reg_count[7:0], 1'b0};
                if (sel_idx == 9'd1) begin
                    body_byte = func;
                end else if (sel_idx == 9'd2) begin
                    body_byte = {reg_count[6:0], 1'b0};
                end else if (sel_idx > 9'd2) begin
                    body_byte = (sel_idx[0]) ? rd_data[7'((sel_idx - 9'd3) >> 1)][15:8]
                                             : rd_data[7'((sel_idx - 9'd3) >> 1)][7:0];
                end
            end
            R_LOG: begin
                body_len = LOG_LEN;
                case (sel_idx)
                    9'd1: body_byte = FC_ACCESS_LOG;
                    9'd2: body_byte = log_start[15:8];
                    9'd3: body_byte = log_start[7:0];
                    9'd4: body_byte = log_count[15:8];
                    9'd5: body_byte = log_count[7:0];
                    default: body_byte = frame[0];
                endcase
            end
            default: begin
                body_len = EXC_LEN;
                if (sel_idx == 9'd1) begin
                    body_byte = func | EXC_FLAG;
                end else if (sel_idx == 9'd2) begin
                    body_byte = exc_code;
                end
            end
        endcase
    end

    crc16_rtu u_tx_crc (
        .clk(clk),
        .resetn(resetn),
        .clear(state == S_LOAD),
        .en(tx_fire && tx_idx < body_len),
        .data(tx_byte),
        .crc(tx_crc),
        .crc_next(tx_crc_next)
    );

    // Transmit walk: body, then CRC low, then CRC high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_idx <= 9'h000;
            tx_byte <= 8'h00;
        end else if (state == S_LOAD) begin
            tx_idx <= 9'h000;
            tx_byte <= body_byte;
        end else if (tx_fire) begin
            tx_idx <= tx_idx + 9'd1;
            if (tx_idx + 9'd1 < body_len) begin
                tx_byte <= body_byte;
            end else if (tx_idx + 9'd1 == body_len) begin
                tx_byte <= tx_crc_next[7:0];
            end else begin
                tx_byte <= tx_crc[15:8];
            end
        end
    end
endmodule

// [rtl/mb_handler_pkg.sv]
// Constants for the serial-line slave message handler.
// Assumes a framing layer upstream that delivers bytes and a frame-end strobe.
package mb_handler_pkg;
    localparam logic [7:0] FC_READ_HOLD = 8'h03;
    localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
    localparam logic [7:0] FC_ACCESS_LOG = 8'h46;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_FUNCTION = 8'h01;
    localparam logic [7:0] EXC_ADDRESS = 8'h02;
    localparam logic [7:0] EXC_DATA = 8'h03;
    localparam logic [7:0] BCAST_ADDR = 8'h00;
    localparam int HOLD_BASE = 40001;
    localparam int MAX_REGS = 125;
    localparam int MIN_FRAME = 4;
    localparam int FRAME_BYTES = 256;
    localparam logic [8:0] READ_QUERY_LEN = 9'h008;
    localparam logic [8:0] LOG_QUERY_LEN = 9'h004;
    localparam logic [8:0] WRITE_HDR_LEN = 9'h009;
    localparam logic [8:0] ECHO_LEN = 9'h006;
    localparam logic [8:0] LOG_LEN = 9'h006;
    localparam logic [8:0] EXC_LEN = 9'h003;
    localparam logic [8:0] READ_HDR_LEN = 9'h003;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [1:0] ST_OK = 2'h0;
    localparam logic [1:0] ST_NO_REG = 2'h1;
    localparam logic [1:0] ST_BAD_DATA = 2'h2;
    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_DECODE = 6'h02,
        S_ACCESS = 6'h04,
        S_FINISH = 6'h08,
        S_LOAD = 6'h10,
        S_SEND = 6'h20
    } state_t;
    typedef enum logic [1:0] {
        R_ECHO = 2'h0,
        R_READ = 2'h1,
        R_LOG = 2'h2,
        R_EXC = 2'h3
    } resp_t;
endpackage
